/* rtl/bct_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - init clears remaining count; charge counts up to full, discharge down to zero.
// - init loads learned full capacity from stored last measured discharge.
// - after a capacity update write the new value back within four seconds.
// - tally counts discharge; light and self steps only while remaining nonzero.
// - tally starts at full minus remaining while within twice near-full of full.
// - skip bit clear subtracts full/128 from the tally start; set means none.
// - tally stops once voltage reaches the second empty level.
// - new full capacity is final tally plus full times low byte over 256.
// - learning needs start near full and no 10 mAh of charge meanwhile.
// - more than 256 mAh estimated loss or temperature below 5 C disqualifies.
// - needs voltage 256 mV under level two, no midrange fix, no overload at or below level two.
// - each capacity update falls at most 256 and rises at most 512.
// - empty levels come from stored pairs or the compensated set when enabled.
// - empty level detection paused while current exceeds the overload threshold.
// - detected empty levels cleared after 10 mAh of charge.
// - levels zero, one, two pull remaining down to 0, 3 percent, low percent.
// - while learning, remaining holds at a level's capacity until voltage reaches it.
// - level one ignored when option bit 7 is set.
// - each self-discharge step removes remaining/256.
// - self rate scaled by powers of two over 10 degree bands.
// - step interval is 640*13500/(256*factor*rate) seconds.
// - interval timer halts while charging; cleared when full while charging.
module bct_core
  import bct_pkg::*;
#(
  parameter int unsigned TICK_CYC = CLK_HZ * TICK_S
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic INIT,
  input wire logic CHG_STEP,
  input wire logic CHG_ACTIVE,
  input wire logic DSG_STEP,
  input wire logic LIGHT_STEP,
  input wire logic MIDRANGE_CORR,
  input wire logic [15:0] VOLTAGE,
  input wire logic [15:0] CURRENT,
  input wire logic signed [7:0] TEMP_C,
  input wire logic [15:0] NV_LAST_DSG,
  input wire logic [7:0] NV_NEAR_FULL,
  input wire logic [7:0] NV_BATT_LOW,
  input wire logic [15:0] NV_OVERLOAD,
  input wire logic [15:0] EMPTY_VOLTAGE_LEVEL_ZERO,
  input wire logic [15:0] EMPTY_VOLTAGE_LEVEL_ONE,
  input wire logic [15:0] EMPTY_VOLTAGE_LEVEL_TWO,
  input wire logic COMPENSATED_EMPTY_THRESHOLDS,
  input wire logic [15:0] COMP_LEVEL_ZERO,
  input wire logic [15:0] COMP_LEVEL_ONE,
  input wire logic [15:0] COMP_LEVEL_TWO,
  input wire logic [7:0] CTRL_MODE,
  input wire logic [7:0] MISC_OPTS,
  input wire logic [7:0] SELF_DSG_RATE,
  output logic [15:0] REMAINING_CHARGE_COUNT,
  output logic [15:0] LEARNED_FULL_CAPACITY,
  output logic LEARNING_DISCHARGE_VALID,
  output logic [2:0] EMPTY_FLAGS,
  output logic SELF_DSG_STEP,
  output logic NV_WR_EN,
  output logic [15:0] NV_WR_DATA
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction

  function automatic logic [7:0] sd_factor(input logic signed [7:0] t);
    sd_factor = 8'h01;
    for (int i = 1; i < SD_BANDS; i++) begin
      if (int'(t) >= TEMP_BAND_C * i) begin
        sd_factor = 8'(1 << i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic init_r, init_nxt, init_go;
  logic [15:0] rem_r, rem_nxt, full_r, full_nxt, tally_r, tally_nxt;
  logic [15:0] chg_r, chg_nxt, est_r, est_nxt, wr_data_r, wr_data_nxt;
  logic learn_r, learn_nxt, sd_step_r, sd_step_nxt, wr_en_r, wr_en_nxt;
  logic [2:0] empty_r, empty_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [23:0] sd_acc_r, sd_acc_nxt, sd_sum;
  logic [15:0] thr0, thr1, thr2, low1, low2, sd_dec, dec, win_lo, tally_init;
  logic [16:0] rem_w, cand, hi, lo;
  logic det_en, ign1, hold, in_win, full_upd, chg_done, sd_hit, tick, sd_clr;
  logic [2:0] below, rise;

  assign init_go = init_r | INIT;
  assign thr0 = COMPENSATED_EMPTY_THRESHOLDS ? COMP_LEVEL_ZERO : EMPTY_VOLTAGE_LEVEL_ZERO;
  assign thr1 = COMPENSATED_EMPTY_THRESHOLDS ? COMP_LEVEL_ONE : EMPTY_VOLTAGE_LEVEL_ONE;
  assign thr2 = COMPENSATED_EMPTY_THRESHOLDS ? COMP_LEVEL_TWO : EMPTY_VOLTAGE_LEVEL_TWO;
  assign ign1 = MISC_OPTS[LVL1_IGNORE_BIT];
  assign det_en = CURRENT <= NV_OVERLOAD;
  assign below = det_en ? {VOLTAGE < thr2, (VOLTAGE < thr1) & ~ign1, VOLTAGE < thr0} : 3'h0;
  assign rise = below & ~empty_r;
  assign low1 = 16'((32'(full_r) * LVL1_PCT) / PCT_DIV);
  assign low2 = 16'((32'(full_r) * 32'(NV_BATT_LOW)) >> BATT_LOW_SHIFT);
  assign win_lo = sat_sub(full_r, 16'({NV_NEAR_FULL, 1'b0}));
  assign in_win = rem_r >= win_lo;
  assign tally_init = sat_sub(full_r - rem_r,
                              CTRL_MODE[TALLY_SKIP_BIT] ? 16'h0000 : (full_r >> TALLY_OFS_SHIFT));
  assign hold = learn_r & ((~empty_r[2] & (rem_r <= low2)) | (~empty_r[1] & ~ign1 & (rem_r <= low1)));
  assign tick = tick_r == TICK_CYC - 1;
  // an accumulator replaces the division: interval ticks x factor x rate reach the limit
  assign sd_sum = sd_acc_r + 24'(sd_factor(TEMP_C)) * 24'(SELF_DSG_RATE);
  assign sd_clr = CHG_ACTIVE & (rem_r == full_r);
  assign sd_hit = tick & ~CHG_ACTIVE & (sd_sum >= 24'(SD_LIMIT));
  assign sd_dec = sd_hit ? rem_r >> SELF_DSG_SHIFT : 16'h0000;
  assign dec = 16'(DSG_STEP) + 16'(LIGHT_STEP) + sd_dec;
  assign full_upd = rise[2] & learn_r & (VOLTAGE < sat_sub(thr2, LVL2_MARGIN_MV));
  assign hi = {1'b0, full_r} + 17'(FULL_MAX_RISE);
  assign lo = 17'(sat_sub(full_r, FULL_MAX_DROP));

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    init_nxt = 1'b0;
    rem_w = {1'b0, rem_r};
    if (!hold) begin
      rem_w = (rem_w >= 17'(dec)) ? rem_w - 17'(dec) : 17'h00000;
    end
    if (CHG_STEP && (rem_w < {1'b0, full_r})) begin
      rem_w = rem_w + 17'h00001;
    end
    if (rise[0]) begin
      rem_w = 17'h00000;
    end
    if (rise[1] && (rem_w > 17'(low1))) begin
      rem_w = 17'(low1);
    end
    if (rise[2] && (rem_w > 17'(low2))) begin
      rem_w = 17'(low2);
    end
    // a fresh detection restarts the charge count, so leftover steps cannot clear it early
    chg_nxt = ((|rise) ? 16'h0000 : chg_r) + 16'(CHG_STEP);
    chg_done = chg_nxt >= VALID_CHG_MAH;
    if (chg_done) begin
      chg_nxt = 16'h0000;
    end
    // a level seen in the clearing cycle stays set
    empty_nxt = (chg_done ? 3'h0 : empty_r) | below;
    learn_nxt = learn_r;
    tally_nxt = tally_r;
    est_nxt = est_r;
    if (in_win && !empty_r[2]) begin
      tally_nxt = tally_init;
      learn_nxt = 1'b1;
      est_nxt = 16'h0000;
    end else if (learn_r && !empty_r[2]) begin
      tally_nxt = tally_r + 16'(DSG_STEP) + ((rem_r != 16'h0000) ? 16'(LIGHT_STEP) + sd_dec : 16'h0000);
      est_nxt = est_r + 16'(LIGHT_STEP) + sd_dec;
    end
    if (chg_done || (est_nxt > EST_LIMIT_MAH) || (int'(TEMP_C) < LEARN_MIN_TEMP_C) || MIDRANGE_CORR ||
        (!det_en && (VOLTAGE <= thr2)) || (rise[2] && !full_upd)) begin
      learn_nxt = 1'b0;
    end
    cand = 17'(tally_r) + 17'(low2);
    if (cand > hi) begin
      cand = hi;
    end else if (cand < lo) begin
      cand = lo;
    end
    full_nxt = full_r;
    wr_en_nxt = 1'b0;
    wr_data_nxt = wr_data_r;
    if (full_upd) begin
      full_nxt = cand[16] ? 16'hFFFF : cand[15:0];
      wr_en_nxt = ~init_go;
      wr_data_nxt = full_nxt;
      if (rem_w > {1'b0, full_nxt}) begin
        rem_w = {1'b0, full_nxt};
      end
    end
    tick_nxt = tick ? 32'h00000000 : tick_r + 32'h00000001;
    sd_acc_nxt = sd_acc_r;
    sd_step_nxt = 1'b0;
    if (sd_clr) begin
      sd_acc_nxt = 24'h000000;
    end else if (tick && !CHG_ACTIVE) begin
      sd_acc_nxt = sd_hit ? 24'h000000 : sd_sum;
      sd_step_nxt = sd_hit;
    end
    if (init_go) begin
      rem_w = 17'(REM_INIT);
      full_nxt = NV_LAST_DSG;
      tally_nxt = 16'h0000;
      learn_nxt = 1'b0;
      empty_nxt = 3'h0;
      chg_nxt = 16'h0000;
      est_nxt = 16'h0000;
      sd_acc_nxt = 24'h000000;
    end
    rem_nxt = rem_w[15:0];
  end

  // reset leaves a pending load so stored capacity is fetched after release
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_r <= 1'b1;
      rem_r <= REM_INIT;
      full_r <= 16'h0000;
      tally_r <= 16'h0000;
      chg_r <= 16'h0000;
      est_r <= 16'h0000;
      learn_r <= 1'b0;
      empty_r <= 3'h0;
      tick_r <= 32'h00000000;
      sd_acc_r <= 24'h000000;
      sd_step_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      init_r <= init_nxt;
      rem_r <= rem_nxt;
      full_r <= full_nxt;
      tally_r <= tally_nxt;
      chg_r <= chg_nxt;
      est_r <= est_nxt;
      learn_r <= learn_nxt;
      empty_r <= empty_nxt;
      tick_r <= tick_nxt;
      sd_acc_r <= sd_acc_nxt;
      sd_step_r <= sd_step_nxt;
      wr_en_r <= wr_en_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  assign REMAINING_CHARGE_COUNT = rem_r;
  assign LEARNED_FULL_CAPACITY = full_r;
  assign LEARNING_DISCHARGE_VALID = learn_r;
  assign EMPTY_FLAGS = empty_r;
  assign SELF_DSG_STEP = sd_step_r;
  assign NV_WR_EN = wr_en_r;
  assign NV_WR_DATA = wr_data_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_rem_bound;
    !init_r |-> rem_r <= full_r;
  endproperty
  a_rem_bound: assert property (p_rem_bound) else $error("remaining above full");

  property p_init_load;
    INIT |=> (full_r == $past(NV_LAST_DSG)) && (rem_r == REM_INIT);
  endproperty
  a_init_load: assert property (p_init_load) else $error("init load wrong");

  property p_nv_write;
    full_upd && !init_go |=> NV_WR_EN && (NV_WR_DATA == full_r);
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("capacity not written back");

  property p_clamp;
    full_upd && !init_go |=> (int'(full_r) <= int'($past(full_r)) + int'(FULL_MAX_RISE)) &&
                             (int'(full_r) + int'(FULL_MAX_DROP) >= int'($past(full_r)));
  endproperty
  a_clamp: assert property (p_clamp) else $error("capacity step too large");

  property p_tally_stop;
    empty_r[2] ##1 (empty_r[2] && !$past(init_go)) |-> tally_r == $past(tally_r);
  endproperty
  a_tally_stop: assert property (p_tally_stop) else $error("tally moved past level two");

  property p_cold;
    int'(TEMP_C) < LEARN_MIN_TEMP_C |=> !learn_r;
  endproperty
  a_cold: assert property (p_cold) else $error("learning kept while cold");

  property p_lvl1_ign;
    ign1 && !empty_r[1] |=> !empty_r[1];
  endproperty
  a_lvl1_ign: assert property (p_lvl1_ign) else $error("ignored level one detected");

  property p_overload;
    !det_en && !empty_r[0] |=> !empty_r[0];
  endproperty
  a_overload: assert property (p_overload) else $error("detection during overload");

  property p_lvl0;
    rise[0] |=> rem_r == 16'h0000;
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("level zero did not empty");

  property p_sd_halt;
    CHG_ACTIVE |=> (sd_acc_r == $past(sd_acc_r)) || (sd_acc_r == 24'h000000);
  endproperty
  a_sd_halt: assert property (p_sd_halt) else $error("timer ran while charging");

endmodule
`default_nettype wire

/* rtl/bct_pkg.sv */
`default_nettype none
package bct_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_S = 1;
  localparam logic [15:0] REM_INIT = 16'h0000;
  localparam logic [15:0] VALID_CHG_MAH = 16'h000A;
  localparam logic [15:0] EST_LIMIT_MAH = 16'h0100;
  localparam logic [15:0] LVL2_MARGIN_MV = 16'h0100;
  localparam logic [15:0] FULL_MAX_DROP = 16'h0100;
  localparam logic [15:0] FULL_MAX_RISE = 16'h0200;
  localparam int LEARN_MIN_TEMP_C = 5;
  localparam int TALLY_SKIP_BIT = 2;
  localparam int LVL1_IGNORE_BIT = 7;
  localparam int TALLY_OFS_SHIFT = 7;
  localparam int BATT_LOW_SHIFT = 8;
  localparam int SELF_DSG_SHIFT = 8;
  localparam int LVL1_PCT = 3;
  localparam int PCT_DIV = 100;
  localparam int TEMP_BAND_C = 10;
  localparam int SD_BANDS = 8;
  // daily rate in tenths of a percent, temperature factor in quarters
  localparam int unsigned SD_LIMIT = 640 * 13500 * 4 * 10 / 256;
endpackage
`default_nettype wire

/* bench/bct_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// parameter store: keeps its contents across device reset, like the real memory
module bct_nv_model (
  input wire logic clk,
  input wire logic preset,
  input wire logic [15:0] preset_val,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output var logic [15:0] last_dsg,
  output var int wr_count
);
  always @(posedge clk) begin
    if (preset) begin
      last_dsg <= preset_val;
    end else if (wr_en) begin
      last_dsg <= wr_data;
      wr_count <= wr_count + 1;
    end
  end
endmodule
`default_nettype wire

/* bench/battery_capacity_tracker_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module battery_capacity_tracker_tb;
  import bct_pkg::*;
  localparam int TK = 10;
  logic clk, rst_n, ini, cs, ca, ds, ls, mc, ce, pre, lv, sds, we;
  logic [15:0] v, cur, ol, z0, z1, z2, c0, c1, c2, rem, full, wd, nvl, pv, f, r;
  logic signed [7:0] t;
  logic [7:0] nf, bl, cm, mo, sr;
  logic [2:0] fl;
  int wc, n_fail, cmp_count, seed, i, n;
  bct_core #(.TICK_CYC(TK)) DUT (
    .CORE_CLK(clk), .RST_N(rst_n), .INIT(ini), .CHG_STEP(cs), .CHG_ACTIVE(ca),
    .DSG_STEP(ds), .LIGHT_STEP(ls), .MIDRANGE_CORR(mc), .VOLTAGE(v), .CURRENT(cur),
    .TEMP_C(t), .NV_LAST_DSG(nvl), .NV_NEAR_FULL(nf), .NV_BATT_LOW(bl), .NV_OVERLOAD(ol),
    .EMPTY_VOLTAGE_LEVEL_ZERO(z0), .EMPTY_VOLTAGE_LEVEL_ONE(z1), .EMPTY_VOLTAGE_LEVEL_TWO(z2),
    .COMPENSATED_EMPTY_THRESHOLDS(ce), .COMP_LEVEL_ZERO(c0), .COMP_LEVEL_ONE(c1),
    .COMP_LEVEL_TWO(c2), .CTRL_MODE(cm), .MISC_OPTS(mo), .SELF_DSG_RATE(sr),
    .REMAINING_CHARGE_COUNT(rem), .LEARNED_FULL_CAPACITY(full),
    .LEARNING_DISCHARGE_VALID(lv), .EMPTY_FLAGS(fl), .SELF_DSG_STEP(sds), .NV_WR_EN(we),
    .NV_WR_DATA(wd));
  bct_nv_model NV (.clk(clk), .preset(pre), .preset_val(pv), .wr_en(we), .wr_data(wd),
    .last_dsg(nvl), .wr_count(wc));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] clampv(input logic [15:0] o, input logic [15:0] x);
    if (x + FULL_MAX_DROP < o) return o - FULL_MAX_DROP;
    if (x > o + FULL_MAX_RISE) return o + FULL_MAX_RISE;
    return x;
  endfunction
  // self-discharge interval in ticks: factor in quarters, rate in tenths
  function automatic int sd_ticks(input int tc, input int rt);
    int q;
    q = 1 << (tc < 0 ? 0 : (tc / 10 > 7 ? 7 : tc / 10));
    return (640 * 13500 * 40 / 256 + q * rt - 1) / (q * rt);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // random gaps between steps so counting cannot rely on back-to-back pulses
  task automatic pulses(input bit chg, input int k);
    int b;
    while (k > 0) begin
      @(posedge clk);
      b = $random(seed) & 1;
      if (chg) cs <= b[0];
      else ds <= b[0];
      k = k - b;
    end
    @(posedge clk);
    cs <= 1'b0;
    ds <= 1'b0;
    ca <= 1'b0;
  endtask
  task automatic prep;
    f = 16'h05DC + 16'($random(seed) & 32'h1FF);
    @(posedge clk);
    pre <= 1'b1;
    pv <= f;
    @(posedge clk);
    pre <= 1'b0;
    ini <= 1'b1;
    @(posedge clk);
    ini <= 1'b0;
    tk(1);
    chk(full, f);
    chk(rem, 16'h0000);
    ca <= 1'b1;
    pulses(1, int'(f) + 5);
    tk(1);
    chk(rem, f);
  endtask
  // lt light steps and an optional midrange correction follow the metered discharge
  task automatic learn(input int dr, input logic signed [7:0] tc, input logic [7:0] lo, input bit upd,
                       input int lt, input bit mid);
    logic [15:0] e, x, h;
    int d, w0;
    bl <= lo;
    t <= tc;
    cm <= 8'($random(seed));
    prep();
    d = int'(f) + dr;
    pulses(0, d);
    repeat (lt) begin
      @(posedge clk);
      ls <= 1'b1;
    end
    @(posedge clk);
    ls <= 1'b0;
    mc <= mid;
    @(posedge clk);
    mc <= 1'b0;
    tk(2);
    // while learning, remaining stops at the higher of the 3 percent and low-battery levels
    h = 16'((32'(f) * lo) >> BATT_LOW_SHIFT);
    if (16'(32'(f) * LVL1_PCT / PCT_DIV) > h) h = 16'(32'(f) * LVL1_PCT / PCT_DIV);
    chk(rem, d + lt >= int'(f) - int'(h) ? h : f - 16'(d + lt));
    chk({15'h0, lv}, {15'h0, upd});
    w0 = wc;
    x = 16'(d + lt) - (cm[TALLY_SKIP_BIT] ? 16'h0000 : f >> 7) + 16'((32'(f) * lo) >> 8);
    e = clampv(f, x);
    v <= z2 - 16'h012C;
    tk(4);
    chk(16'(wc - w0), {15'h0, upd});
    if (!upd) chk(full, f);
    else if (e != x) chk(full, e);
    else chk(16'(full - e + 16'h0001) <= 16'h0002 ? 16'h0001 : 16'h0000, 16'h0001);
    if (upd && e != x) chk(wd, e);
    v <= 16'h0FA0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hACD3;
    {ini, cs, ca, ds, ls, mc, ce, mo, cur, sr} = '0;
    {rst_n, pre, pv, v, t, ol} = {2'b01, 16'h05DC, 16'h0FA0, 8'sd25, 16'h1388};
    {z0, z1, z2, c0, c1, c2} = {16'h076C, 16'h07D0, 16'h0BB8, 16'h09C4, 16'h0A28, 16'h0BB8};
    nf = 8'h10 + 8'($random(seed) & 15);
    {bl, cm} = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    learn(-1400, 8'sd25, 8'h00, 1, 0, 0);
    learn(700, 8'sd25, 8'h40, 1, 0, 0);
    learn(-1200, 8'sd2, 8'h00, 0, 0, 0);
    learn(-200, 8'sd25, 8'h19, 1, 0, 0);
    // 256 estimated steps still qualify and must land in the tally; one more disqualifies
    learn(-400, 8'sd25, 8'h08, 1, 256, 0);
    learn(-1400, 8'sd25, 8'h00, 0, 257, 0);
    learn(-1400, 8'sd25, 8'h00, 0, 0, 1);
    // cold keeps learning out of the way of the level checks
    t <= 8'sd0;
    bl <= 8'h40;
    prep();
    cur <= ol + 16'h0001;
    v <= 16'h079E;
    tk(3);
    chk({13'h0, fl}, 16'h0000);
    chk(rem, f);
    cur <= 16'h0000;
    tk(3);
    chk({13'h0, fl}, 16'h0006);
    r = 16'(32'(f) * 3 / 100);
    chk(rem, r);
    chk(full, f);
    v <= 16'h0FA0;
    ca <= 1'b1;
    pulses(1, 9);
    tk(2);
    chk({13'h0, fl}, 16'h0006);
    pulses(1, 1);
    tk(2);
    chk({13'h0, fl}, 16'h0000);
    mo <= 8'h80;
    v <= 16'h079E;
    tk(3);
    chk({13'h0, fl}, 16'h0004);
    chk(rem, r + 16'h000A);
    ce <= 1'b1;
    tk(3);
    chk({13'h0, fl}, 16'h0005);
    chk(rem, 16'h0000);
    {ce, mo, v, sr} <= {1'b0, 8'h00, 16'h0FA0, 8'hFF};
    for (i = 0; i < 2; i++) begin
      t <= i ? 8'sd35 : 8'sd75;
      prep();
      n = 0;
      while (sds !== 1'b1 && n < 20000) begin
        tk(1);
        n++;
      end
      r = 16'(sd_ticks(i ? 35 : 75, 255));
      chk(n >= (r - 1) * TK && n <= r * TK + 3 ? 16'h0001 : 16'h0000, 16'h0001);
      chk(rem, f - (f >> 8));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
